// file: hw/serial_pkg.sv
// Constants and carrier types for the serial port baud and framing block
//------------------------------------------------------------------
//------------------------------------------------------------------
package serial_pkg;
    localparam int ADDR_W = 3;
    localparam logic [2:0] REG_BAUD_HIGH = 3'h0;
    localparam logic [2:0] REG_BAUD_LOW = 3'h1;
    localparam logic [2:0] REG_FRAMING = 3'h2;
    localparam logic [2:0] REG_ENABLES = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;
    localparam logic [2:0] REG_DATA = 3'h5;
    localparam logic [2:0] REG_IRQ_MASK = 3'h6;
    localparam logic [2:0] REG_RX_NINTH = 3'h7;
    localparam int BDH_BRK_IE = 7;
    localparam int BDH_EDGE_IE = 6;
    localparam int FR_LOOP = 7;
    localparam int FR_FREEZE = 6;
    localparam int FR_RECEIVER_SOURCE_SELECT = 5;
    localparam int FR_NINE = 4;
    localparam int FR_WAKE = 3;
    localparam int FR_ILT = 2;
    localparam int FR_PE = 1;
    localparam int FR_PT = 0;
    localparam int EN_TX9 = 5;
    localparam int EN_LONG_BRK = 4;
    localparam int EN_TE = 3;
    localparam int EN_RE = 2;
    localparam int EN_SEND_BRK = 0;
    localparam int ST_TXE = 5;
    localparam logic [7:0] ST_W1C_MASK = 8'hDB;
    localparam logic [7:0] BAUD_LOW_RESET = 8'h04;
    localparam logic [3:0] SAMPLE_PHASE = 4'h7;
    localparam logic [3:0] LAST_PHASE = 4'hF;
    localparam logic [3:0] LEN_EIGHT = 4'hA;
    localparam logic [3:0] LEN_NINE = 4'hB;
    localparam logic [3:0] LEN_LONG_BRK = 4'hD;
    localparam logic [3:0] IDLE_SAT = 4'hF;
    localparam logic [7:0] BRK_DETECT_TICKS = 8'hB0;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
endpackage

// file: hw/serial_port.sv
// Serial port with baud generator, framing options and register file
`timescale 1ns/100ps
module serial_port
(
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire serial_pkg::bus_req_t bus_in,
    output logic [7:0] rdata_out,
    input wire logic cpu_wait_in,
    input wire logic rx_pin_in,
    input wire logic tx_pin_in,
    output logic tx_pin_out,
    output logic tx_pin_oe_out,
    output logic rx_pin_owned_out,
    output logic irq_out
);
    import serial_pkg::*;

    typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_DONE} rx_state_t;

    function automatic logic ones_odd(input logic [8:0] v);
        ones_odd = ^v;
    endfunction

    //------------------------------------------------------------------
    // Register file
    //------------------------------------------------------------------
    logic [7:0] bdh_reg, framing_reg, enables_reg, mask_reg, rdata_reg, tx_buf_reg;
    logic [7:0] status_reg, status_next, rx_data_reg, rd_mux, st_view, st_set, st_clr;
    logic [12:0] divisor_reg;
    logic armed_reg, tx_empty_reg, rx9_reg;
    logic brk_set, edge_set, idle_set, rx_done, perr_set, ferr_set;
    logic tx_start;

    wire wr_bdh = bus_in.wr && bus_in.addr == REG_BAUD_HIGH;
    wire wr_bdl = bus_in.wr && bus_in.addr == REG_BAUD_LOW;
    wire wr_en = bus_in.wr && bus_in.addr == REG_ENABLES;
    wire wr_data = bus_in.wr && bus_in.addr == REG_DATA;
    wire loop = framing_reg[FR_LOOP];
    wire nine = framing_reg[FR_NINE];
    wire pe = framing_reg[FR_PE];
    wire odd = framing_reg[FR_PT];
    wire te = enables_reg[EN_TE];
    wire re = enables_reg[EN_RE];
    wire [7:0] mask_eff = {bdh_reg[BDH_BRK_IE], bdh_reg[BDH_EDGE_IE], mask_reg[5:0]};
    wire [3:0] char_len = nine ? LEN_NINE : LEN_EIGHT;

    assign st_view = {status_reg[7:6], tx_empty_reg, status_reg[4:0]};
    assign st_set = {brk_set, edge_set, 1'b0, rx_done, idle_set, 1'b0, perr_set, ferr_set};
    assign st_clr = (bus_in.wr && bus_in.addr == REG_STATUS) ? (bus_in.wdata & ST_W1C_MASK) : 8'h00;
    assign status_next = (status_reg & ~st_clr) | st_set;
    assign irq_out = |(st_view & mask_eff);

    always_comb
    begin
        unique case (bus_in.addr)
            REG_BAUD_HIGH: rd_mux = bdh_reg;
            REG_BAUD_LOW: rd_mux = divisor_reg[7:0];
            REG_FRAMING: rd_mux = framing_reg;
            REG_ENABLES: rd_mux = enables_reg;
            REG_STATUS: rd_mux = st_view;
            REG_DATA: rd_mux = rx_data_reg;
            REG_IRQ_MASK: rd_mux = {bdh_reg[7:6], mask_reg[5:0]};
            REG_RX_NINTH: rd_mux = {rx9_reg, 7'h00};
        endcase
    end
    assign rdata_out = rdata_reg;

    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            bdh_reg <= 8'h00;
            divisor_reg <= {5'h00, BAUD_LOW_RESET};
            framing_reg <= 8'h00;
            enables_reg <= 8'h00;
            mask_reg <= 8'h00;
            status_reg <= 8'h00;
            rdata_reg <= 8'h00;
            armed_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= bus_in.rd ? rd_mux : 8'h00;
            status_reg <= status_next;
            if (wr_bdh)
                bdh_reg <= {bus_in.wdata[7:6], 1'b0, bus_in.wdata[4:0]};
            if (wr_bdl)
                divisor_reg <= {bdh_reg[4:0], bus_in.wdata};
            if (bus_in.wr && bus_in.addr == REG_FRAMING)
                framing_reg <= bus_in.wdata;
            if (wr_en)
                enables_reg <= {2'b00, bus_in.wdata[5:2], 1'b0, bus_in.wdata[0]};
            if (bus_in.wr && bus_in.addr == REG_IRQ_MASK)
                mask_reg <= {2'b00, bus_in.wdata[5:0]};
            if (wr_en && (bus_in.wdata[EN_TE] || bus_in.wdata[EN_RE]))
                armed_reg <= 1'b1;
        end
    end

    //------------------------------------------------------------------
    // Baud generator, sixteen ticks per bit
    //------------------------------------------------------------------
    logic [12:0] baud_cnt_reg;
    wire gen_on = armed_reg && divisor_reg != 13'h0000;
    wire run = gen_on && !(cpu_wait_in && framing_reg[FR_FREEZE]);
    wire tick16 = run && baud_cnt_reg == divisor_reg - 13'h0001;
    // Restart on a new divisor so a smaller one cannot make the count wrap
    wire [12:0] baud_cnt_next = (!run || tick16 || wr_bdl) ? 13'h0000 : baud_cnt_reg + 13'h0001;

    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            baud_cnt_reg <= 13'h0000;
        else
            baud_cnt_reg <= baud_cnt_next;
    end

    //------------------------------------------------------------------
    // Transmitter
    //------------------------------------------------------------------
    tx_state_t tx_state_reg;
    logic [12:0] tx_frame_reg;
    logic [3:0] tx_phase_reg, tx_cnt_reg, tx_len_reg;
    logic tx_pin_reg;
    wire [7:0] td = tx_buf_reg;
    wire par_bit = odd ^ ones_odd(nine ? {1'b0, td} : {2'b00, td[6:0]});
    wire [8:0] chr = nine ? {pe ? par_bit : enables_reg[EN_TX9], td}
                          : {1'b1, pe ? par_bit : td[7], td[6:0]};
    wire send_brk = enables_reg[EN_SEND_BRK];
    wire [3:0] brk_len = enables_reg[EN_LONG_BRK] ? LEN_LONG_BRK : char_len;
    wire tx_line = tx_state_reg == TX_SEND ? tx_frame_reg[0] : 1'b1;
    // Frames start on a tick so the start bit lasts a full bit time
    assign tx_start = tx_state_reg == TX_IDLE && te && tick16 && (send_brk || !tx_empty_reg);
    wire tx_bit_end = tx_state_reg == TX_SEND && tick16 && tx_phase_reg == LAST_PHASE;

    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            tx_state_reg <= TX_IDLE;
            tx_frame_reg <= 13'h1FFF;
            tx_phase_reg <= 4'h0;
            tx_cnt_reg <= 4'h0;
            tx_len_reg <= LEN_EIGHT;
            tx_buf_reg <= 8'h00;
            tx_empty_reg <= 1'b1;
            tx_pin_reg <= 1'b1;
        end
        else
        begin
            tx_pin_reg <= tx_line;
            if (wr_data)
            begin
                tx_buf_reg <= bus_in.wdata;
                tx_empty_reg <= 1'b0;
            end
            unique case (tx_state_reg)
                TX_IDLE:
                    if (tx_start)
                    begin
                        tx_state_reg <= TX_SEND;
                        tx_frame_reg <= send_brk ? 13'h0000 : {3'b111, chr, 1'b0};
                        tx_len_reg <= send_brk ? brk_len : char_len;
                        tx_phase_reg <= 4'h0;
                        tx_cnt_reg <= 4'h0;
                        if (!send_brk && !wr_data)
                            tx_empty_reg <= 1'b1;
                    end
                TX_SEND:
                begin
                    if (tick16)
                        tx_phase_reg <= tx_phase_reg + 4'h1;
                    if (tx_bit_end)
                    begin
                        tx_frame_reg <= {1'b1, tx_frame_reg[12:1]};
                        tx_cnt_reg <= tx_cnt_reg + 4'h1;
                        if (tx_cnt_reg == tx_len_reg - 4'h1)
                            tx_state_reg <= TX_IDLE;
                    end
                end
            endcase
        end
    end
    assign tx_pin_out = tx_pin_reg;
    assign tx_pin_oe_out = te || tx_state_reg == TX_SEND;

    //------------------------------------------------------------------
    // Receiver input selection and edge, break, idle detection
    //------------------------------------------------------------------
    logic rx_s1_reg, rx_s2_reg, txp_s1_reg, txp_s2_reg, rx_line_d_reg;
    logic [7:0] low_cnt_reg;
    logic [3:0] idle_ph_reg, idle_cnt_reg;
    wire rx_line = loop ? (framing_reg[FR_RECEIVER_SOURCE_SELECT] ? txp_s2_reg : tx_line) : rx_s2_reg;
    wire fall = rx_line_d_reg && !rx_line;
    wire idle_tick = tick16 && idle_ph_reg == LAST_PHASE;
    wire [3:0] idle_need = char_len;
    assign rx_pin_owned_out = re && !loop;
    assign edge_set = re && fall;
    assign brk_set = re && tick16 && !rx_line && low_cnt_reg == BRK_DETECT_TICKS - 8'h01;
    assign idle_set = re && idle_tick && rx_line && idle_cnt_reg == idle_need - 4'h1;

    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            txp_s1_reg <= 1'b1;
            txp_s2_reg <= 1'b1;
            rx_line_d_reg <= 1'b1;
            low_cnt_reg <= 8'h00;
            idle_ph_reg <= 4'h0;
            idle_cnt_reg <= IDLE_SAT;
        end
        else
        begin
            rx_s1_reg <= rx_pin_in;
            rx_s2_reg <= rx_s1_reg;
            txp_s1_reg <= tx_pin_in;
            txp_s2_reg <= txp_s1_reg;
            rx_line_d_reg <= rx_line;
            if (rx_line)
                low_cnt_reg <= 8'h00;
            else if (tick16 && low_cnt_reg != BRK_DETECT_TICKS)
                low_cnt_reg <= low_cnt_reg + 8'h01;
            if (tick16)
                idle_ph_reg <= idle_ph_reg + 4'h1;
            if (!rx_line || (framing_reg[FR_ILT] && rx_done))
                idle_cnt_reg <= 4'h0;
            else if (idle_tick && idle_cnt_reg != IDLE_SAT)
                idle_cnt_reg <= idle_cnt_reg + 4'h1;
        end
    end

    //------------------------------------------------------------------
    // Receiver shifter
    //------------------------------------------------------------------
    rx_state_t rx_state_reg;
    logic [10:0] rx_sr_reg;
    logic [3:0] rx_phase_reg, rx_bit_reg;
    wire rx_stop = nine ? rx_sr_reg[10] : rx_sr_reg[9];
    wire rx_odd = ones_odd(nine ? rx_sr_reg[9:1] : {1'b0, rx_sr_reg[8:1]});
    wire rx_sample = rx_state_reg == RX_SHIFT && tick16 && rx_phase_reg == SAMPLE_PHASE;
    assign rx_done = rx_state_reg == RX_DONE;
    assign ferr_set = rx_done && !rx_stop;
    assign perr_set = rx_done && pe && rx_odd != odd;

    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rx_state_reg <= RX_IDLE;
            rx_sr_reg <= 11'h000;
            rx_phase_reg <= 4'h0;
            rx_bit_reg <= 4'h0;
            rx_data_reg <= 8'h00;
            rx9_reg <= 1'b0;
        end
        else
        begin
            unique case (rx_state_reg)
                RX_IDLE:
                    if (re && run && fall)
                    begin
                        rx_state_reg <= RX_SHIFT;
                        rx_phase_reg <= 4'h0;
                        rx_bit_reg <= 4'h0;
                    end
                RX_SHIFT:
                begin
                    if (tick16)
                        rx_phase_reg <= rx_phase_reg + 4'h1;
                    if (!re)
                        rx_state_reg <= RX_IDLE;
                    else if (rx_sample)
                    begin
                        rx_sr_reg[rx_bit_reg] <= rx_line;
                        rx_bit_reg <= rx_bit_reg + 4'h1;
                        if (rx_bit_reg == 4'h0 && rx_line)
                            rx_state_reg <= RX_IDLE;
                        else if (rx_bit_reg == char_len - 4'h1)
                            rx_state_reg <= RX_DONE;
                    end
                end
                RX_DONE:
                begin
                    rx_state_reg <= RX_IDLE;
                    rx_data_reg <= rx_sr_reg[8:1];
                    rx9_reg <= rx_sr_reg[9];
                end
            endcase
        end
    end

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    logic [12:0] gap_reg;
    logic gap_ok_reg;
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            gap_reg <= 13'h0000;
            gap_ok_reg <= 1'b0;
        end
        else
        begin
            gap_reg <= tick16 ? 13'h0000 : gap_reg + 13'h0001;
            gap_ok_reg <= run && !wr_bdl && (tick16 || gap_ok_reg);
        end
    end

    AST_ZERO_DIV_OFF: assert property (divisor_reg == 13'h0000 |-> !tick16)
        else $error("baud tick with zero divisor");
    AST_ARM_FIRST: assert property (!armed_reg |-> !tick16)
        else $error("baud tick before first enable");
    AST_LOW_APPLIES: assert property (wr_bdl |=> divisor_reg == {$past(bdh_reg[4:0]), $past(bus_in.wdata)})
        else $error("low write did not apply divisor");
    AST_HIGH_HOLDS: assert property (wr_bdh |=> $stable(divisor_reg))
        else $error("high write changed working divisor");
    AST_TICK_GAP: assert property (tick16 && gap_ok_reg |-> gap_reg + 13'h0001 == divisor_reg)
        else $error("baud tick spacing wrong");
    AST_FREEZE_WAIT: assert property (cpu_wait_in && framing_reg[FR_FREEZE] |-> !tick16)
        else $error("baud ran while frozen in wait");
    AST_TX_DRIVE: assert property (te |-> tx_pin_oe_out)
        else $error("transmit pin not driven while enabled");
    AST_RX_RELEASE: assert property (!re || loop |-> !rx_pin_owned_out)
        else $error("receive pin held while released");
    AST_LOOP_START: assert property (rx_state_reg == RX_IDLE && loop && !framing_reg[FR_RECEIVER_SOURCE_SELECT]
        && re && run && $fell(tx_line) |=> rx_state_reg == RX_SHIFT)
        else $error("loop start bit missed");
    AST_BRK_IRQ: assert property (status_reg[7] && bdh_reg[BDH_BRK_IE] |-> irq_out)
        else $error("break interrupt not raised");
    AST_EDGE_IRQ: assert property (edge_set && bdh_reg[BDH_EDGE_IE] |=> irq_out)
        else $error("edge interrupt not raised");
    AST_IDLE_HIGH: assert property (tx_state_reg == TX_IDLE |=> tx_pin_out)
        else $error("transmit line not idle high");
    AST_BRK_STICKY: assert property (brk_set |=> status_reg[7])
        else $error("break flag not set");
    AST_EDGE_STICKY: assert property (edge_set |=> status_reg[6])
        else $error("edge flag not set");
    AST_START_LOW: assert property (tx_start |=> !tx_line)
        else $error("start bit not low");
    AST_CHAR_LEN: assert property (tx_start && !send_brk
        |=> tx_len_reg == ($past(nine) ? LEN_NINE : LEN_EIGHT))
        else $error("character length wrong");
    AST_PARITY_GEN: assert property (tx_start && pe && !send_brk
        |=> (^(tx_frame_reg[9:1] & ($past(nine) ? 9'h1ff : 9'h0ff))) == $past(odd))
        else $error("parity bit wrong");
    AST_RDATA_IDLE: assert property (!bus_in.rd |=> rdata_out == 8'h00)
        else $error("read data outside read cycle");
    COV_FROZEN: cover property (gen_on && !run);

    COV_TX_FRAME: cover property (tx_start ##1 tx_state_reg == TX_SEND);
    COV_RX_DONE: cover property (rx_done && !ferr_set);
    COV_BREAK: cover property (brk_set);
    COV_IDLE: cover property (idle_set);
endmodule

// file: bench/remote_serial.sv
// Remote serial transceiver model facing the serial port
`timescale 1ns/100ps
module remote_serial
(
    input wire logic clk_in,
    input wire logic line_in,
    input wire logic nine_in,
    input wire logic [15:0] bit_clks_in,
    output logic line_out,
    output logic [8:0] word_out,
    output logic stop_out,
    output logic valid_out,
    output logic [15:0] low_len_out
);
    // ----------------------------------------
    // Receive side, mid-bit sampling
    // ----------------------------------------
    initial
    begin
        line_out = 1'b1;
        valid_out = 1'b0;
        forever
        begin
            @(negedge line_in);
            fork
                measure();
            join_none
            repeat (bit_clks_in / 2) @(posedge clk_in);
            word_out <= '0;
            for (int i = 0; i < 8 + nine_in; i++)
            begin
                repeat (bit_clks_in) @(posedge clk_in);
                word_out[i] <= line_in;
            end
            repeat (bit_clks_in) @(posedge clk_in);
            stop_out <= line_in;
            valid_out <= 1'b1;
            @(posedge clk_in);
            valid_out <= 1'b0;
        end
    end

    // Start bit length in clocks
    task automatic measure();
        low_len_out = 16'h0001;
        forever
        begin
            @(posedge clk_in);
            #1;
            if (line_in !== 1'b0)
                break;
            low_len_out++;
        end
    endtask

    // ----------------------------------------
    // Transmit side: low span, data bits, stop
    // ----------------------------------------
    task automatic send(input logic [8:0] w, input int nbits, input int low_clks);
        line_out <= 1'b0;
        repeat (low_clks) @(posedge clk_in);
        for (int i = 0; i < nbits; i++)
        begin
            line_out <= w[i];
            repeat (bit_clks_in) @(posedge clk_in);
        end
        line_out <= 1'b1;
        repeat (bit_clks_in) @(posedge clk_in);
    endtask
endmodule

// file: bench/async_serial_port_baud_and_framing_tb.sv
// Self-checking bench for the serial port baud and framing block
`timescale 1ns/100ps
module async_serial_port_baud_and_framing_tb;
    import serial_pkg::*;
    typedef struct {
        string what;
        logic [8:0] val;
        logic [8:0] mask;
        logic [15:0] len;
    } exp_t;
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic cpu_wait_in = 1'b0;
    logic sw_route = 1'b0;
    logic nine = 1'b0;
    logic rd_pend = 1'b0;
    bus_req_t bus_in = '0;
    logic [15:0] bit_clks = 16'h0020;
    logic [7:0] rdata_out;
    logic tx_pin_out, tx_pin_oe_out, rx_pin_owned_out, irq_out;
    logic far_tx, far_stop, far_valid;
    logic [8:0] far_word;
    logic [15:0] far_len;
    logic [31:0] seed = 32'he761_d0bd;
    int mismatches = 0;
    int n_checks = 0;
    exp_t exp_rd[$];
    exp_t exp_ser[$];
    // Pull-up where nobody drives
    wire line_seen = tx_pin_oe_out ? tx_pin_out : 1'b1;
    wire tx_wire = tx_pin_oe_out ? tx_pin_out : (sw_route ? far_tx : 1'b1);
    wire rx_wire = sw_route ? 1'b0 : far_tx;

    always #12.5 clk_sys_in = ~clk_sys_in;

    serial_port i_serial_port
    (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .bus_in(bus_in),
        .rdata_out(rdata_out), .cpu_wait_in(cpu_wait_in), .rx_pin_in(rx_wire),
        .tx_pin_in(tx_wire), .tx_pin_out(tx_pin_out), .tx_pin_oe_out(tx_pin_oe_out),
        .rx_pin_owned_out(rx_pin_owned_out), .irq_out(irq_out)
    );
    remote_serial i_remote_serial
    (
        .clk_in(clk_sys_in), .line_in(line_seen), .nine_in(nine), .bit_clks_in(bit_clks),
        .line_out(far_tx), .word_out(far_word), .stop_out(far_stop),
        .valid_out(far_valid), .low_len_out(far_len)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Mode m is nine-bit, parity enable, odd parity
    function automatic logic [8:0] frame(input logic [7:0] d, input logic [2:0] m, input logic t9);
        logic p;
        p = (m[2] ? ^d : ^d[6:0]) ^ m[0];
        if (!m[2])
            return m[1] ? {1'b0, p, d[6:0]} : {1'b0, d};
        return m[1] ? {p, d} : {t9, d};
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        bus_in <= '{addr: a, wdata: d, wr: w, rd: ~w};
        @(posedge clk_sys_in);
        bus_in <= '0;
        @(posedge clk_sys_in);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [2:0] a, input logic [8:0] v, input logic [8:0] m, input string s);
        exp_rd.push_back('{s, v, m, 16'h0000});
        bus(1'b0, a, 8'h00);
    endtask

    task automatic wait_ser();
        int n = 0;
        while (exp_ser.size() > 0 && n < 20000)
        begin
            @(posedge clk_sys_in);
            n++;
        end
        check("frame wait", 16'(exp_ser.size()), 16'h0000);
    endtask

    task automatic send_tx(input logic [7:0] d, input logic [2:0] m, input logic t9,
        input logic [15:0] len);
        exp_ser.push_back('{"frame", frame(d, m, t9), 9'h1ff, len});
        wr(REG_DATA, d);
        wait_ser();
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------
    // Result watcher
    // ----------------------------------------
    always @(posedge clk_sys_in)
    begin
        exp_t e;
        if (rd_pend && exp_rd.size() > 0)
        begin
            e = exp_rd.pop_front();
            check(e.what, 16'({1'b0, rdata_out} & e.mask), 16'(e.val));
        end
        if (far_valid === 1'b1)
        begin
            e = exp_ser.pop_front();
            check(e.what, 16'(far_word & e.mask), 16'(e.val));
            check("stop", 16'(far_stop), 16'h0001);
            if (e.len != 0)
                check("bit time", far_len, e.len);
        end
        rd_pend <= bus_in.rd;
    end

    initial
    begin
        repeat (60000) @(posedge clk_sys_in);
        mismatches++;
        $display("BAD watchdog expected finish seen hang");
        final_report();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        logic [7:0] d;
        logic t9;
        int n;
        repeat (12) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        rd(REG_BAUD_LOW, {1'b0, BAUD_LOW_RESET}, 9'h0ff, "low reset");
        rd(REG_FRAMING, 9'h000, 9'h0ff, "framing reset");
        check("oe idle", 16'(tx_pin_oe_out), 16'h0000);
        check("rx pin idle", 16'(rx_pin_owned_out), 16'h0000);
        check("line idle", 16'(tx_pin_out), 16'h0001);
        repeat (3)
        begin
            d = 8'(rnd());
            wr(REG_FRAMING, d);
            rd(REG_FRAMING, {1'b0, d}, 9'h0ff, "framing");
        end
        wr(REG_BAUD_HIGH, 8'hff);
        rd(REG_BAUD_HIGH, 9'h0df, 9'h0ff, "baud high");
        wr(REG_BAUD_HIGH, 8'h00);
        wr(REG_BAUD_LOW, 8'h02);
        wr(REG_FRAMING, 8'h00);
        $display("done registers");
        wr(REG_ENABLES, 8'h08);
        check("oe on", 16'(tx_pin_oe_out), 16'h0001);
        wr(REG_BAUD_HIGH, 8'h1f);
        send_tx(8'h35, 3'b000, 1'b0, 16'h0020);
        for (int m = 0; m < 8; m++)
        begin
            d = 8'(rnd()) | 8'h01;
            t9 = d[6];
            n = 1 + m % 2;
            bit_clks = 16'(16 * n);
            nine = m[2];
            wr(REG_BAUD_HIGH, 8'h00);
            wr(REG_BAUD_LOW, 8'(n));
            wr(REG_FRAMING, {3'b000, m[2], 2'b00, m[1:0]});
            wr(REG_ENABLES, {2'b00, t9, 5'b01000});
            send_tx(d, 3'(m), t9, bit_clks);
        end
        $display("done transmit modes");
        nine = 1'b0;
        bit_clks = 16'h0020;
        wr(REG_FRAMING, 8'h00);
        wr(REG_BAUD_LOW, 8'h02);
        wr(REG_ENABLES, 8'h08);
        cpu_wait_in <= 1'b1;
        send_tx(8'h5b, 3'b000, 1'b0, 16'h0020);
        wr(REG_FRAMING, 8'h40);
        cpu_wait_in <= 1'b0;
        exp_ser.push_back('{"frozen frame", 9'h0c0, 9'h1ff, 16'h0000});
        wr(REG_DATA, 8'hff);
        n = 0;
        while (tx_pin_out !== 1'b0 && n < 100)
        begin
            @(posedge clk_sys_in);
            n++;
        end
        cpu_wait_in <= 1'b1;
        repeat (200) @(posedge clk_sys_in);
        check("frozen line", 16'(tx_pin_out), 16'h0000);
        cpu_wait_in <= 1'b0;
        wait_ser();
        $display("done wait mode");
        wr(REG_ENABLES, 8'h0c);
        check("rx pin used", 16'(rx_pin_owned_out), 16'h0001);
        for (int pt = 0; pt < 2; pt++)
        begin
            d = 8'(rnd());
            d[7] = ^d[6:0] ^ pt[0];
            wr(REG_FRAMING, {6'h00, 1'b1, pt[0]});
            wr(REG_STATUS, ST_W1C_MASK);
            i_remote_serial.send({1'b0, ~d[7], d[6:0]}, 8, bit_clks);
            rd(REG_STATUS, 9'h002, 9'h002, "parity error");
            wr(REG_STATUS, ST_W1C_MASK);
            i_remote_serial.send({1'b0, d}, 8, bit_clks);
            rd(REG_STATUS, 9'h010, 9'h012, "parity good");
            rd(REG_DATA, {2'b00, d[6:0]}, 9'h07f, "rx data");
        end
        wr(REG_FRAMING, 8'h10);
        d = 8'(rnd());
        i_remote_serial.send({1'b1, d}, 9, bit_clks);
        rd(REG_RX_NINTH, 9'h080, 9'h080, "ninth bit");
        rd(REG_DATA, {1'b0, d}, 9'h0ff, "nine data");
        $display("done receive");
        wr(REG_FRAMING, 8'h00);
        wr(REG_STATUS, ST_W1C_MASK);
        check("irq quiet", 16'(irq_out), 16'h0000);
        wr(REG_BAUD_HIGH, 8'h40);
        i_remote_serial.send(9'h0f0, 8, bit_clks);
        check("edge irq", 16'(irq_out), 16'h0001);
        wr(REG_STATUS, 8'h40);
        check("edge cleared", 16'(irq_out), 16'h0000);
        wr(REG_BAUD_HIGH, 8'h80);
        i_remote_serial.send(9'h000, 0, 12 * bit_clks);
        check("break irq", 16'(irq_out), 16'h0001);
        wr(REG_BAUD_HIGH, 8'h00);
        check("break polled", 16'(irq_out), 16'h0000);
        rd(REG_STATUS, 9'h080, 9'h080, "break flag");
        wr(REG_STATUS, ST_W1C_MASK);
        $display("done interrupts");
        wr(REG_FRAMING, 8'h80);
        check("rx pin freed", 16'(rx_pin_owned_out), 16'h0000);
        sw_route <= 1'b1;
        d = 8'(rnd()) | 8'h01;
        send_tx(d, 3'b000, 1'b0, 16'h0020);
        rd(REG_DATA, {1'b0, d}, 9'h0ff, "loop data");
        wr(REG_FRAMING, 8'ha0);
        wr(REG_ENABLES, 8'h04);
        repeat (24) @(posedge clk_sys_in);
        check("tx pin freed", 16'(tx_pin_oe_out), 16'h0000);
        d = 8'(rnd());
        i_remote_serial.send({1'b0, d}, 8, bit_clks);
        rd(REG_DATA, {1'b0, d}, 9'h0ff, "single wire");
        $display("done loop modes");
        wr(REG_FRAMING, 8'h00);
        wr(REG_ENABLES, 8'h08);
        wr(REG_BAUD_LOW, 8'h00);
        wr(REG_DATA, 8'h00);
        n = 0;
        repeat (400)
        begin
            @(posedge clk_sys_in);
            n += int'(tx_pin_out !== 1'b1);
        end
        check("zero divisor", 16'(n), 16'h0000);
        $display("done zero divisor");
        final_report();
    end
endmodule
